// ### core/edge_sync.v
`timescale 1ns/100ps
`include "timer_meas_defs.vh"
// Two-flop synchroniser plus rising/falling edge pulses
module edge_sync
(
   input wire pclk,
   input wire presetn,
   input wire async_in,
   output wire level,
   output wire rise,
   output wire fall
);
   reg meta_q;
   reg sync_q;
   reg last_q;

   // ==================================================
   // Only sync_q reads meta_q
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign rise = sync_q & ~last_q;
   assign fall = ~sync_q & last_q;
endmodule

// ### core/prescaler.v
`timescale 1ns/100ps
`include "timer_meas_defs.vh"
// Makes one-cycle enables at pclk/1, /8 and /32
module prescaler
(
   input wire pclk,
   input wire presetn,
   output wire sysclk_div1,
   output wire sysclk_div8,
   output wire sysclk_div32
);
   reg [4:0] div_q;

   // ==================================================
   // Free-running divider
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_q <= 5'h00;
      else
         div_q <= div_q + 5'h01;
   end

   assign sysclk_div1 = 1'b1;
   assign sysclk_div8 = (div_q[2:0] == `DIV8_LAST);
   assign sysclk_div32 = (div_q == `DIV32_LAST);
endmodule

// ### core/timer_event_count_pulse_measure.v
`timescale 1ns/100ps
`include "timer_meas_defs.vh"
// Contract
// - Event mode counts selected pin edges.
// - Event mode may count other timer overflow.
// - Decrement per event; underflow reloads, interrupts.
// - Underflow every programmed value plus one.
// - Start flag one runs, zero halts.
// - Event mode read returns live count.
// - Stopped write loads reload and counter.
// - Running write loads reload only.
// - Channel one: overflows only, no measurement.
// - Measure: count up, capture, restart zero.
// - Edge interrupt except first edge.
// - Overflow interrupts and sets overflow flag.
// - Later mode write clears overflow flag; here only while running, after a count cycle.
// - Measure read returns reload register.
// - Result indeterminate before second edge.
// - Measure mode counter writes ignored.
// - Period: same-polarity edge to edge.
// - Mode from two low mode bits.
module timer_event_count_pulse_measure
#(
   parameter HAS_PIN = 1
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire channel_pulse_input_pin,
   input wire other_timer_ovf,
   input wire subclock_div32,
   output reg irq,
   output reg underflow_pulse
);
   // ==================================================
   // Register map, one aligned word each
   // START  [0] runs the channel; clearing it halts and forgets edge history
   // MODE   [1:0] 0 timer (not counted here), 1 event count, 2 measure
   // MODE   [3:2] edge 0 fall, 1 rise, 2 both; period uses rise if 1, else fall
   // MODE   [4] width instead of period, [5] overflow flag, read only
   // MODE   [7:6] measure clock pclk/1, /8, /32 or subclock rise
   // COUNT  [15:0] live count in event mode, last result in measure mode
   // STATUS [0] underflow, [1] measured edge, [2] overflow; write one clears
   // MASK   same layout as STATUS; irq is high while any unmasked bit is set
   // SRC    [0] counts other_timer_ovf instead of the pin
   // Unmapped offsets answer with pslverr and read as zero.
   // Limitation: the pin is seen three cycles late and pulses shorter than
   // one pclk period may be lost; measured values share that delay.

   // Enables and synchronised edges
   wire sysclk_div1;
   wire sysclk_div8;
   wire sysclk_div32;
   wire pin_rise;
   wire pin_fall;
   wire sub_rise;

   // Software-visible and counter state
   reg start_q;
   reg [7:0] mode_q;
   reg use_ovf_q;
   reg [15:0] count_q;
   reg [15:0] reload_q;
   reg [2:0] status_q;
   reg [2:0] mask_q;
   reg [1:0] edges_q;
   reg ovf_armed_q;
   reg [2:0] ev_d;
   reg [31:0] rdata_d;

   // Decoded controls
   wire [1:0] msel;
   wire [1:0] esel;
   wire [1:0] csel;
   wire acc;
   wire wr;
   wire pin_edge;
   wire event_tick;
   wire meas_tick;
   wire meas_edge;
   wire is_event;
   wire is_meas;
   wire mapped;

   // ==================================================
   // Divider and input synchronisers
   // pclk/1 is a constant enable, kept so the clock select stays uniform
   prescaler u_pre
   (
      .pclk(pclk),
      .presetn(presetn),
      .sysclk_div1(sysclk_div1),
      .sysclk_div8(sysclk_div8),
      .sysclk_div32(sysclk_div32)
   );

   edge_sync u_pin
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(channel_pulse_input_pin),
      .level(),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Subclock arrives from another domain; sync then use its rise
   edge_sync u_sub
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(subclock_div32),
      .level(),
      .rise(sub_rise),
      .fall()
   );

   // ==================================================
   // Decode of mode and bus strobes
   assign msel = mode_q[`MODE_SEL_HI:`MODE_SEL_LO];
   assign esel = mode_q[`MODE_EDGE_HI:`MODE_EDGE_LO];
   assign csel = mode_q[`MODE_CLK_HI:`MODE_CLK_LO];
   assign is_event = (msel == `MODE_EVENT);
   // A channel without pin never measures
   assign is_meas = (msel == `MODE_MEAS) && (HAS_PIN != 0);
   // acc marks the one edge at which a transfer completes
   assign acc = psel & penable & pready;
   assign wr = acc & pwrite;
   // Only the listed word offsets decode; anything else is refused
   assign mapped = (paddr == `OFS_START) || (paddr == `OFS_MODE) ||
      (paddr == `OFS_COUNT) || (paddr == `OFS_STATUS) ||
      (paddr == `OFS_MASK) || (paddr == `OFS_SRC);

   // Edge selection for event counting
   // Both edges count twice per pin period
   assign pin_edge = (esel == `EDGE_RISE) ? pin_rise :
      (esel == `EDGE_BOTH) ? (pin_rise | pin_fall) : pin_fall;

   // Source: pin, or other timer's overflow; no pin forces overflow
   assign event_tick = ((use_ovf_q || (HAS_PIN == 0)) ? other_timer_ovf :
      pin_edge);

   // Measurement count clock
   // Subclock ticks arrive three cycles late; keep it below pclk/4
   assign meas_tick = (csel == `CLK_DIV8) ? sysclk_div8 :
      (csel == `CLK_DIV32) ? sysclk_div32 :
      (csel == `CLK_SUB32) ? sub_rise : sysclk_div1;

   // Period uses one polarity, width uses both
   // Width mode measures high and low phases alternately
   assign meas_edge = mode_q[`MODE_MEAS_WIDTH] ? (pin_rise | pin_fall) :
      ((esel == `EDGE_RISE) ? pin_rise : pin_fall);

   // ==================================================
   // Counter, reload and event detection
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_q <= `ZERO16;
         reload_q <= `ZERO16;
         edges_q <= 2'h0;
         ovf_armed_q <= 1'b0;
         ev_d <= 3'h0;
      end
      else
      begin
         ev_d <= 3'h0;
         // Start low clears the edge history
         if (!start_q)
            edges_q <= 2'h0;
         // A mode write restarts the wait for a count cycle
         if (wr && (paddr == `OFS_MODE))
            ovf_armed_q <= 1'b0;
         // Outside measure mode COUNT writes reach reload, the counter only when stopped
         if (wr && (paddr == `OFS_COUNT) && !is_meas)
         begin
            reload_q <= pwdata[15:0];
            if (!start_q)
               count_q <= pwdata[15:0];
         end
         // Event counting: down, reload on underflow
         if (start_q && is_event && event_tick)
         begin
            if (count_q == `ZERO16)
            begin
               // Underflow every reload+1 events
               count_q <= reload_q;
               ev_d[`ST_UNDER] <= 1'b1;
            end
            else
               count_q <= count_q - `ONE16;
         end
         // Measuring: capture and restart at each edge
         else if (start_q && is_meas)
         begin
            if (meas_edge)
            begin
               reload_q <= count_q;
               count_q <= `ZERO16;
               // The first edge after start only opens the measurement
               if (edges_q != 2'h0)
                  ev_d[`ST_EDGE] <= 1'b1;
               if (edges_q != 2'h2)
                  edges_q <= edges_q + 2'h1;
            end
            // No edge: count the prescaled clock; wraps past the top
            else if (meas_tick)
            begin
               count_q <= count_q + `ONE16;
               if (count_q == `ONES16)
               begin
                  ev_d[`ST_OVF] <= 1'b1;
                  ovf_armed_q <= 1'b0;
               end
               else
                  ovf_armed_q <= 1'b1;
            end
         end
      end
   end

   // ==================================================
   // Software registers; hardware set beats write-one clear
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         start_q <= 1'b0;
         mode_q <= 8'h00;
         use_ovf_q <= 1'b0;
         mask_q <= 3'h0;
      end
      else
      begin
         // Plain register writes land at the pready edge
         if (wr && (paddr == `OFS_START))
            start_q <= pwdata[0];
         if (wr && (paddr == `OFS_SRC))
            use_ovf_q <= pwdata[0];
         if (wr && (paddr == `OFS_MASK))
            mask_q <= pwdata[2:0];
         if (wr && (paddr == `OFS_MODE))
         begin
            mode_q[4:0] <= pwdata[4:0];
            mode_q[`MODE_CLK_HI:`MODE_CLK_LO] <= pwdata[`MODE_CLK_HI:`MODE_CLK_LO];
         end
         // Overflow flag: set on overflow, cleared by a mode write while running once a count cycle has passed
         if (ev_d[`ST_OVF])
            mode_q[`MODE_OVF_BIT] <= 1'b1;
         else if (wr && (paddr == `OFS_MODE) && start_q && ovf_armed_q)
            mode_q[`MODE_OVF_BIT] <= 1'b0;
      end
   end

   // ==================================================
   // Sticky status bits, one process per bit
   // A hardware set in the same cycle as a write-one clear wins
   genvar g;
   generate
      for (g = 0; g < `ST_W; g = g + 1)
      begin : g_status
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               status_q[g] <= 1'b0;
            else if (ev_d[g])
               status_q[g] <= 1'b1;
            else if (wr && (paddr == `OFS_STATUS) && pwdata[g])
               status_q[g] <= 1'b0;
         end
      end
   endgenerate

   // ==================================================
   // Read mux
   // Decoded from paddr alone; the slave registers it one cycle later
   always @*
   begin
      rdata_d = 32'h00000000;
      case (paddr)
         `OFS_START: rdata_d[0] = start_q;
         `OFS_MODE: rdata_d[7:0] = mode_q;
         `OFS_COUNT: rdata_d[15:0] = is_meas ? reload_q : count_q;
         `OFS_STATUS: rdata_d[2:0] = status_q;
         `OFS_MASK: rdata_d[2:0] = mask_q;
         `OFS_SRC: rdata_d[0] = use_ovf_q;
         default: rdata_d = 32'h00000000;
      endcase
   end

   // ==================================================
   // APB slave: one wait state, answer registered
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else
      begin
         // Ready pulses one cycle into the access phase
         pready <= psel & penable & ~pready;
         if (psel & penable & ~pready)
         begin
            // A write reads back zero so stale data never looks like an answer
            prdata <= pwrite ? 32'h00000000 : rdata_d;
            pslverr <= ~mapped;
         end
         // pslverr only ever stands together with pready
         else
            pslverr <= 1'b0;
      end
   end

   // ==================================================
   // Interrupt and underflow outputs
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq <= 1'b0;
         underflow_pulse <= 1'b0;
      end
      else
      begin
         // irq lags status by one cycle so it comes straight from a flop
         irq <= |(status_q & mask_q);
         // underflow_pulse feeds the event input of a neighbouring channel
         underflow_pulse <= ev_d[`ST_UNDER];
      end
   end
endmodule

// ### core/timer_meas_defs.vh
`ifndef TIMER_MEAS_DEFS_VH
`define TIMER_MEAS_DEFS_VH
// ==================================================
// Register byte offsets
`define OFS_START 8'h00
`define OFS_MODE 8'h04
`define OFS_COUNT 8'h08
`define OFS_STATUS 8'h0C
`define OFS_MASK 8'h10
`define OFS_SRC 8'h14
// ==================================================
// Mode register fields
`define MODE_SEL_LO 0
`define MODE_SEL_HI 1
`define MODE_EDGE_LO 2
`define MODE_EDGE_HI 3
`define MODE_MEAS_WIDTH 4
`define MODE_CLK_LO 6
`define MODE_CLK_HI 7
`define MODE_OVF_BIT 5
// Mode encodings
`define MODE_TIMER 2'h0
`define MODE_EVENT 2'h1
`define MODE_MEAS 2'h2
// Edge select
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h2
// Measurement clock select
`define CLK_DIV1 2'h0
`define CLK_DIV8 2'h1
`define CLK_DIV32 2'h2
`define CLK_SUB32 2'h3
// Prescaler terminal counts
`define DIV8_LAST 5'h07
`define DIV32_LAST 5'h1F
// Status bits
`define ST_UNDER 0
`define ST_EDGE 1
`define ST_OVF 2
`define ST_W 3
// 16-bit constants
`define ZERO16 16'h0000
`define ONES16 16'hFFFF
`define ONE16 16'h0001
`endif

// ### test/pulse_source.sv
`timescale 1ns/100ps
// ==========
// Square wave on the channel pin
module pulse_source
(
   input wire pclk,
   input wire run,
   input wire [7:0] high_len,
   input wire [7:0] low_len,
   output reg pin = 1'b0
);
   reg [7:0] cnt_q = 8'h00;
   // Rests low when stopped; halting it while high still gives one last falling edge
   always @(posedge pclk)
   begin
      if (!run)
      begin
         pin <= 1'b0;
         cnt_q <= 8'h00;
      end
      else if (cnt_q == 8'h00)
      begin
         pin <= !pin;
         cnt_q <= (pin ? low_len : high_len) - 8'h01;
      end
      else
         cnt_q <= cnt_q - 8'h01;
   end
endmodule

// ### test/test_timer_event_count_pulse_measure.sv
`timescale 1ns/100ps
`include "timer_meas_defs.vh"
// ==========
// Scenario bench for a pin channel and a pinless channel on one bus
module test_timer_event_count_pulse_measure;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg ovf = 1'b0, run = 1'b0, err;
   reg [7:0] paddr = 8'h00, hi = 8'h04, lo = 8'h04;
   reg [31:0] pwdata = 32'h0, rd, r1;
   wire [31:0] prdata;
   wire pready, pslverr, irq, pin, uf, uf1;
   integer errors = 0, check_count = 0, e, uf_n = 0, uf1_n = 0;
   // Channel with a pin, fed by the pulse source
   timer_event_count_pulse_measure u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .channel_pulse_input_pin(pin),
      .other_timer_ovf(ovf), .subclock_div32(1'b0), .irq(irq), .underflow_pulse(uf));
   // Pinless channel on the same bus; it may only count other_timer_ovf
   timer_event_count_pulse_measure #(.HAS_PIN(0)) u_ch1 (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(), .pready(), .pslverr(), .channel_pulse_input_pin(pin),
      .other_timer_ovf(ovf), .subclock_div32(1'b0), .irq(), .underflow_pulse(uf1));
   pulse_source u_src (.pclk(pclk), .run(run), .high_len(hi), .low_len(lo), .pin(pin));
   // Count underflow pulses of both channels
   always @(posedge pclk)
   begin
      if (uf === 1'b1)
         uf_n <= uf_n + 1;
      if (uf1 === 1'b1)
         uf1_n <= uf1_n + 1;
   end
   // 25 MHz clock
   always #20 pclk = ~pclk;
   task summarize;
   begin
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
   begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
         errors = errors + 1;
         $display("wrong value at %0t: %h, expected %h", $time, got, exp);
      end
   end
   endtask
   // One APB transfer; an idle edge first keeps two transfers from colliding
   task bus(input w, input [7:0] a, input [31:0] d);
      integer i;
   begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20 && pready !== 1'b1; i = i + 1)
         @(posedge pclk);
      if (pready !== 1'b1)
      begin
         errors = errors + 1;
         summarize;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rdr(input [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   // k pulses of 4 high, 4 low, then time for the pin synchroniser
   task pulses(input integer k);
   begin
      run <= 1'b1;
      repeat (8 * k) @(posedge pclk);
      run <= 1'b0;
      repeat (6) @(posedge pclk);
   end
   endtask
   // Rising-edge counting, reload, masked then live interrupt
   task t_event;
   begin
      wr(`OFS_MODE, 32'h5);
      wr(`OFS_COUNT, 32'h3);
      rdr(`OFS_COUNT);
      chk(rd, 32'h3);
      wr(`OFS_START, 32'h1);
      pulses(2);
      rdr(`OFS_COUNT);
      chk(rd, 32'h1);
      wr(`OFS_COUNT, 32'h5);
      pulses(2);
      rdr(`OFS_COUNT);
      chk(rd, 32'h5);
      chk({31'h0, irq}, 32'h0);
      wr(`OFS_MASK, 32'h1);
      wr(`OFS_STATUS, 32'h1);
      pulses(5);
      chk({31'h0, irq}, 32'h0);
      pulses(1);
      chk({31'h0, irq}, 32'h1);
      chk(uf_n, 32'h2);
      chk(uf1_n, 32'h0);
   end
   endtask
   // Other timer's overflow as source, on both channels
   task t_src;
   begin
      wr(`OFS_START, 32'h0);
      wr(`OFS_MODE, 32'h1);
      wr(`OFS_SRC, 32'h1);
      wr(`OFS_COUNT, 32'h2);
      wr(`OFS_START, 32'h1);
      repeat (3)
      begin
         ovf <= 1'b1;
         @(posedge pclk);
         ovf <= 1'b0;
         @(posedge pclk);
      end
      rdr(`OFS_COUNT);
      chk(rd, 32'h2);
      chk(uf_n, 32'h3);
      chk(uf1_n, 32'h1);
   end
   endtask
   // Free-running measure count overflows; a later mode write clears the flag
   task t_ovf;
   begin
      wr(`OFS_START, 32'h0);
      wr(`OFS_MODE, 32'h2);
      wr(`OFS_STATUS, 32'h7);
      wr(`OFS_START, 32'h1);
      repeat (65540) @(posedge pclk);
      rdr(`OFS_MODE);
      chk(rd & 32'h20, 32'h20);
      rdr(`OFS_STATUS);
      chk(rd & 32'h4, 32'h4);
      wr(`OFS_MODE, 32'h2);
      rdr(`OFS_MODE);
      chk(rd & 32'h20, 32'h0);
   end
   endtask
   // Every edge choice in turn
   task t_edges;
   begin
      for (e = 0; e < 3; e = e + 1)
      begin
         wr(`OFS_START, 32'h0);
         wr(`OFS_MODE, 32'h1 | (e << 2));
         wr(`OFS_COUNT, 32'h10);
         wr(`OFS_START, 32'h1);
         pulses(2);
         rdr(`OFS_COUNT);
         chk(rd, (e == 2) ? 32'hC : 32'hE);
      end
   end
   endtask
   // Measuring: silent first edge; the held result ignores writes
   task t_meas;
   begin
      wr(`OFS_START, 32'h0);
      wr(`OFS_MODE, 32'h6);
      wr(`OFS_STATUS, 32'h7);
      wr(`OFS_START, 32'h1);
      pulses(1);
      rdr(`OFS_STATUS);
      chk(rd & 32'h2, 32'h0);
      pulses(1);
      rdr(`OFS_STATUS);
      chk(rd & 32'h2, 32'h2);
      rdr(`OFS_COUNT);
      r1 = rd;
      wr(`OFS_COUNT, 32'h1234);
      rdr(`OFS_COUNT);
      chk(rd, r1);
      wr(`OFS_START, 32'h0);
      wr(`OFS_START, 32'h1);
      pulses(3);
      rdr(`OFS_COUNT);
      chk(rd, {24'h0, hi + lo - 8'h01});
      wr(`OFS_START, 32'h0);
      wr(`OFS_MODE, 32'h12);
      wr(`OFS_START, 32'h1);
      pulses(3);
      rdr(`OFS_COUNT);
      chk(rd, {24'h0, hi - 8'h01});
   end
   endtask
   // Unmapped offset is refused
   task t_err;
   begin
      rdr(8'h20);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
   end
   endtask
   // Reset, then the scenarios in order
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_event;
      t_edges;
      t_src;
      t_meas;
      t_ovf;
      t_err;
      summarize;
   end
endmodule

// ### test/timer_checker_assertions.sv
`timescale 1ns/100ps
`include "timer_meas_defs.vh"
// ==========
// Bus and interrupt checks
module timer_checker
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire irq
);
   // One clock domain, so clock and reset are given once
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
   ready_access_a: assert property (pready |-> psel && penable) else $error("stray pready");
   answer_time_a: assert property (psel && penable && !pready |=> pready) else $error("late");
   err_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
   err_map_a: assert property (pready && paddr > `OFS_SRC |-> pslverr) else $error("no pslverr");
   err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("bad data");
   rdata_hold_a: assert property ($changed(prdata) |-> $past(psel && penable))
      else $error("read data changed outside a transfer");
   // The interrupt only drops after a status or mask write lands
   irq_clear_a: assert property ($fell(irq) |-> $past(pready && pwrite, 2) ||
      $past(pready && pwrite, 3)) else $error("irq dropped");
   cover property (pready && pwrite);
   cover property (pready && pslverr);
   cover property ($rose(irq));
endmodule
bind timer_event_count_pulse_measure timer_checker u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq(irq));
